// ---- rtl/nvs_cfg.svh ----
// Timing constants and command encodings for the store/restore sequencer.
// Assumes a 50 MHz system clock; every count is derived from its printed time.
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH

`define NVS_CLK_PERIOD_NS          20
// All times round down, none below one cycle
`define NVS_POWERUP_RESTORE_MS_LO  40
`define NVS_POWERUP_RESTORE_MS_HI  20
`define NVS_RESTORE_US             600
`define NVS_SAVE_MS                8
`define NVS_WRITE_GRACE_NS         25
`define NVS_CMD_ACT_US             500
`define NVS_SLEEP_ENTRY_MS         8
`define NVS_STANDBY_ENTRY_US       100
`define NVS_WAKE_MS_LO             40
`define NVS_WAKE_MS_HI             20
`define NVS_BUSY_RELEASE_US        5
`define NVS_BUSY_HIGH_DRIVE_NS     500

`define NVS_MS_CYC(ms)  ((ms) * 1000000 / `NVS_CLK_PERIOD_NS)
`define NVS_US_CYC(us)  ((us) * 1000 / `NVS_CLK_PERIOD_NS)
`define NVS_NS_CYC(ns)  (((ns) / `NVS_CLK_PERIOD_NS) > 0 ? ((ns) / `NVS_CLK_PERIOD_NS) : 1)

`define NVS_GRACE_CYC      `NVS_NS_CYC(`NVS_WRITE_GRACE_NS)
`define NVS_BUSY_HIGH_CYC  `NVS_NS_CYC(`NVS_BUSY_HIGH_DRIVE_NS)
`define NVS_RELEASE_CYC    `NVS_US_CYC(`NVS_BUSY_RELEASE_US)

// Command codes on the special-function port
`define NVS_CMD_SAVE     2'h0
`define NVS_CMD_RESTORE  2'h1
`define NVS_CMD_SLEEP    2'h2

`endif

// ---- rtl/nvs_pkg.sv ----
// Types shared by the store/restore sequencer.
// Constants live in nvs_cfg.svh.
`default_nettype none
package nvs_pkg;
   typedef enum logic [1:0] {
      NVS_OP_SAVE    = 2'h0,
      NVS_OP_RESTORE = 2'h1,
      NVS_OP_SLEEP   = 2'h2,
      NVS_OP_NONE    = 2'h3
   } nvs_op_e;

   typedef struct packed {
      logic    valid;
      nvs_op_e op;
   } nvs_cmd_s;

   typedef struct packed {
      logic accessOk;
      logic sramWriteEn;
      logic busy;
      logic asleep;
      logic standby;
   } nvs_status_s;
endpackage : nvs_pkg
`default_nettype wire

// ---- rtl/nvs_sequencer.sv ----
// Store/restore sequencer: power-up restore, power-down save, pin save,
// serial commands, sleep and standby, with the store/busy pin driver.
// Assumes all inputs synchronous to clk_sys; reset follows the supply trip.
//
// Contract
// - Power-up restore completes within 40 ms or 20 ms after supply trip.
// - Skip power-down or pin save when SRAM unwritten since last cycle.
// - Keep SRAM writes enabled up to 25 ns when a save begins.
// - Ignore reads and writes during save, restore, or low supply.
// - Save and restore lock serial interface: restore 600 us, save 8 ms.
// - Begin acting on special command within 500 us of receipt.
// - Reach sleep within 8 ms after sleep instruction.
// - Enter standby within 100 us after bus STOP.
// - Wake from sleep takes up to 40 or 20 ms; master waits.
// - SRAM access disabled while store/busy pin held low outside.
// - Accessible again within 5 us after store/busy pin returns high.
// - Drive store/busy pin high at most 500 ns after save, then release.
`include "nvs_cfg.svh"
`default_nettype none

module nvs_sequencer #(
   parameter bit          LOW_VOLT_VARIANT = 1'b0,
   parameter int unsigned RESTORE_CYC      = `NVS_US_CYC(`NVS_RESTORE_US),
   parameter int unsigned SAVE_CYC         = `NVS_MS_CYC(`NVS_SAVE_MS),
   parameter int unsigned CMD_ACT_CYC      = `NVS_US_CYC(`NVS_CMD_ACT_US),
   parameter int unsigned SLEEP_CYC        = `NVS_MS_CYC(`NVS_SLEEP_ENTRY_MS),
   parameter int unsigned STANDBY_CYC      = `NVS_US_CYC(`NVS_STANDBY_ENTRY_US),
   parameter int unsigned POWERUP_CYC      = LOW_VOLT_VARIANT ?
                          `NVS_MS_CYC(`NVS_POWERUP_RESTORE_MS_LO) :
                          `NVS_MS_CYC(`NVS_POWERUP_RESTORE_MS_HI),
   parameter int unsigned WAKE_CYC         = LOW_VOLT_VARIANT ?
                          `NVS_MS_CYC(`NVS_WAKE_MS_LO) :
                          `NVS_MS_CYC(`NVS_WAKE_MS_HI)
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // Supply monitor
   input  wire logic              supplyLow,
   // Serial front end
   input  wire nvs_pkg::nvs_cmd_s cmdIn,
   input  wire logic              busStop,
   input  wire logic              busStart,
   input  wire logic              sramWriteDone,
   // Store/busy pin, open drain with active pull-up phase
   input  wire logic              storeBusyPinIn,
   output logic                   storeBusyPinOut,
   output logic                   storeBusyPinOe_n,
   // Status
   output nvs_pkg::nvs_status_s   status
);
   localparam int unsigned CW = 24;

   // Every count loads as count minus one, so zero or an oversize count would wrap
   if (SAVE_CYC >= (1 << CW) || POWERUP_CYC >= (1 << CW) || WAKE_CYC >= (1 << CW)
       || RESTORE_CYC >= (1 << CW) || SLEEP_CYC >= (1 << CW)
       || CMD_ACT_CYC >= (1 << CW) || STANDBY_CYC >= (1 << CW)
       || SAVE_CYC == 0 || RESTORE_CYC == 0 || POWERUP_CYC == 0 || WAKE_CYC == 0
       || SLEEP_CYC == 0 || CMD_ACT_CYC == 0 || STANDBY_CYC == 0) begin : g_bad_count
      $error("nvs_sequencer: timing count out of range");
   end

   typedef enum logic [3:0] {
      NVS_S_PWRUP, NVS_S_IDLE, NVS_S_CMDWAIT, NVS_S_GRACE, NVS_S_SAVE,
      NVS_S_RESTORE, NVS_S_HIDRIVE, NVS_S_RELEASE, NVS_S_SLEEPIN, NVS_S_SLEEP,
      NVS_S_WAKE, NVS_S_PINHOLD
   } nvs_state_e;

   nvs_state_e      state_reg, state_next;
   logic [CW-1:0]   cnt_reg, cnt_next;
   logic            dirty_reg, dirty_next;
   logic            saveLowPower_reg, saveLowPower_next;
   nvs_pkg::nvs_op_e pendOp_reg, pendOp_next;
   logic [CW-1:0]   sbCnt_reg;
   logic            standby_reg;
   logic            pinBusy_reg;

   wire cntDone    = (cnt_reg == '0);
   wire pinRequest = !storeBusyPinIn && storeBusyPinOe_n;
   wire cmdValid   = cmdIn.valid && (cmdIn.op != nvs_pkg::NVS_OP_NONE);
   wire inNvCycle  = (state_reg == NVS_S_SAVE) || (state_reg == NVS_S_RESTORE)
                     || (state_reg == NVS_S_PWRUP);

   function automatic logic [CW-1:0] nvs_load(input int unsigned cyc);
      nvs_load = CW'(cyc - 1);
   endfunction : nvs_load

   always_comb begin
      state_next        = state_reg;
      cnt_next          = cntDone ? cnt_reg : cnt_reg - 1'b1;
      dirty_next        = dirty_reg | sramWriteDone;
      saveLowPower_next = saveLowPower_reg;
      pendOp_next       = pendOp_reg;
      unique case (state_reg)
         NVS_S_PWRUP: if (cntDone) begin
            state_next = NVS_S_IDLE;
            dirty_next = sramWriteDone;
         end
         NVS_S_IDLE: begin
            if (supplyLow || pinRequest) begin
               // Unwritten array: nothing to save
               if (dirty_reg) begin
                  state_next        = NVS_S_GRACE;
                  saveLowPower_next = supplyLow;
                  cnt_next          = nvs_load(`NVS_GRACE_CYC);
               end else if (pinRequest) begin
                  state_next = NVS_S_PINHOLD;
               end
            end else if (cmdValid) begin
               state_next  = NVS_S_CMDWAIT;
               pendOp_next = cmdIn.op;
               cnt_next    = nvs_load(CMD_ACT_CYC);
            end
         end
         NVS_S_CMDWAIT: begin
            // Acting on the first cycle is well within the allowed delay
            if (supplyLow) begin
               state_next = NVS_S_IDLE;
            end else begin
               unique case (pendOp_reg)
                  nvs_pkg::NVS_OP_SAVE: begin
                     state_next        = NVS_S_SAVE;
                     saveLowPower_next = 1'b0;
                     cnt_next          = nvs_load(SAVE_CYC);
                  end
                  nvs_pkg::NVS_OP_RESTORE: begin
                     state_next = NVS_S_RESTORE;
                     cnt_next   = nvs_load(RESTORE_CYC);
                  end
                  nvs_pkg::NVS_OP_SLEEP: begin
                     state_next = NVS_S_SLEEPIN;
                     cnt_next   = nvs_load(SLEEP_CYC);
                  end
                  default: state_next = NVS_S_IDLE;
               endcase
            end
         end
         // A write landing on a closing edge keeps the array marked: set beats clear
         NVS_S_GRACE: if (cntDone) begin
            state_next = NVS_S_SAVE;
            cnt_next   = nvs_load(SAVE_CYC);
            dirty_next = sramWriteDone;
         end
         NVS_S_SAVE: if (cntDone) begin
            state_next = saveLowPower_reg ? NVS_S_SAVE : NVS_S_HIDRIVE;
            cnt_next   = nvs_load(`NVS_BUSY_HIGH_CYC);
            dirty_next = sramWriteDone;
         end
         NVS_S_RESTORE: if (cntDone) begin
            state_next = NVS_S_IDLE;
            dirty_next = sramWriteDone;
         end
         NVS_S_HIDRIVE: if (cntDone) begin
            state_next = storeBusyPinIn ? NVS_S_IDLE : NVS_S_PINHOLD;
         end
         NVS_S_PINHOLD: if (storeBusyPinIn) begin
            state_next = NVS_S_RELEASE;
            cnt_next   = nvs_load(`NVS_RELEASE_CYC);
         end
         NVS_S_RELEASE: if (cntDone || cnt_reg != '0) begin
            state_next = NVS_S_IDLE;
         end
         NVS_S_SLEEPIN: if (cntDone || cnt_reg != '0) begin
            state_next = NVS_S_SLEEP;
         end
         NVS_S_SLEEP: if (busStart) begin
            state_next = NVS_S_WAKE;
            cnt_next   = nvs_load(WAKE_CYC);
         end
         NVS_S_WAKE: if (cntDone) begin
            state_next = NVS_S_IDLE;
         end
         default: state_next = NVS_S_PWRUP;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg        <= NVS_S_PWRUP;
         cnt_reg          <= nvs_load(POWERUP_CYC);
         dirty_reg        <= 1'b0;
         saveLowPower_reg <= 1'b0;
         pendOp_reg       <= nvs_pkg::NVS_OP_NONE;
      end else begin
         state_reg        <= state_next;
         cnt_reg          <= cnt_next;
         dirty_reg        <= dirty_next;
         saveLowPower_reg <= saveLowPower_next;
         pendOp_reg       <= pendOp_next;
      end
   end

   // Standby follows a STOP after a quiet interval; any start cancels it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sbCnt_reg   <= '0;
         standby_reg <= 1'b0;
      end else if (busStart || state_reg != NVS_S_IDLE) begin
         sbCnt_reg   <= '0;
         standby_reg <= 1'b0;
      end else if (busStop) begin
         sbCnt_reg <= nvs_load(STANDBY_CYC);
      end else if (sbCnt_reg != '0) begin
         sbCnt_reg <= sbCnt_reg - 1'b1;
         standby_reg <= (sbCnt_reg == CW'(1));
      end
   end

   // Pin driver: low during nonvolatile cycles, high briefly after a pin or command save
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pinBusy_reg      <= 1'b1;
         storeBusyPinOut  <= 1'b0;
         storeBusyPinOe_n <= 1'b0;
      end else begin
         pinBusy_reg      <= inNvCycle;
         storeBusyPinOut  <= (state_next == NVS_S_HIDRIVE);
         storeBusyPinOe_n <= !((state_next == NVS_S_SAVE) || (state_next == NVS_S_RESTORE)
                              || (state_next == NVS_S_PWRUP)
                              || (state_next == NVS_S_HIDRIVE));
      end
   end

   // Grace window keeps the write path open; everything else blocks access
   wire writeOpen  = (state_reg == NVS_S_IDLE && !supplyLow && !pinRequest)
                     || (state_reg == NVS_S_GRACE);
   wire accessOpen = (state_reg == NVS_S_IDLE) && !supplyLow && !pinRequest;
   wire asleepNow  = (state_reg == NVS_S_SLEEP);
   assign status = '{accessOk: accessOpen, sramWriteEn: writeOpen, busy: pinBusy_reg,
                     asleep: asleepNow, standby: standby_reg};

endmodule : nvs_sequencer
`default_nettype wire

// ---- testbench/nvs_pin_model.sv ----
// Store/busy pin with pull-up and an outside save requester.
// Assumes the requester changes pullLow on clock edges.
`default_nettype none
module nvs_pin_model (
   // Clock and request
   input  wire logic clk_sys,
   input  wire logic pullLow,
   // Device driver
   input  wire logic storeBusyPinOut,
   input  wire logic storeBusyPinOe_n,
   // Resolved level
   output logic      pinLevel
);
   timeunit 1ns;
   timeprecision 1ns;
   logic holdLow_reg = 1'b0;
   // Stretch keeps every request at least a full cycle long
   always_ff @(posedge clk_sys) begin
      holdLow_reg <= pullLow;
   end
   assign pinLevel = (pullLow || holdLow_reg) ? 1'b0 : (storeBusyPinOe_n ? 1'b1 : storeBusyPinOut);
endmodule : nvs_pin_model
`default_nettype wire

// ---- testbench/nvs_sequencer_props.sv ----
// Checker for nvs_sequencer, bound to its ports.
// Assumes the short counts the bench uses.
`default_nettype none
module nvs_sequencer_props #(
   parameter int RESTORE_CYC = 10,
   parameter int POWERUP_CYC = 20
) (
   // Clock, reset and inputs
   input wire logic              clk_sys, reset, supplyLow, busStop, busStart,
   input wire logic              sramWriteDone, storeBusyPinIn,
   input wire nvs_pkg::nvs_cmd_s cmdIn,
   // Outputs
   input wire logic              storeBusyPinOut, storeBusyPinOe_n,
   input wire nvs_pkg::nvs_status_s status
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RstMax = RESTORE_CYC + 3;
   localparam int PupMax = POWERUP_CYC + 3;
   logic [7:0] hiCnt_reg;
   wire  logic pinLow = !storeBusyPinOe_n && !storeBusyPinOut;
   wire  logic cmdOk = status.accessOk && cmdIn.valid;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Counts cycles of active high drive
   always_ff @(posedge clk_sys) begin
      hiCnt_reg <= (reset || storeBusyPinOe_n || !storeBusyPinOut) ? 8'h00 : hiCnt_reg + 8'h01;
   end
   busy_locked_a: assert property (pinLow [*2] |-> !$past(status.accessOk))
      else $error("access open while pin driven low");
   pin_held_a: assert property ((!storeBusyPinIn && storeBusyPinOe_n) [*2] |-> !status.accessOk)
      else $error("access open while pin held low");
   pin_recover_a: assert property ($rose(storeBusyPinIn) |-> ##[0:251] status.accessOk)
      else $error("no access after pin release");
   high_drive_a: assert property (hiCnt_reg <= 8'h19)
      else $error("pin driven high too long");
   cmd_acted_a: assert property (cmdOk && cmdIn.op != nvs_pkg::NVS_OP_NONE
      |-> ##[1:7] (!status.accessOk || status.asleep)) else $error("command not acted on");
   restore_lock_a: assert property (cmdOk && cmdIn.op == nvs_pkg::NVS_OP_RESTORE
      |-> ##2 !status.accessOk ##[1:RstMax] status.accessOk) else $error("restore length wrong");
   write_grace_a: assert property (status.sramWriteEn && !status.accessOk |=> !status.sramWriteEn)
      else $error("write grace too long");
   sleep_entry_a: assert property (cmdOk && cmdIn.op == nvs_pkg::NVS_OP_SLEEP
      |-> ##[1:10] status.asleep) else $error("sleep not reached");
   standby_entry_a: assert property (status.accessOk && busStop
      |-> ##[1:8] (status.standby || !status.accessOk)) else $error("standby not reached");
   powerup_done_a: assert property ($fell(reset) |-> ##[0:PupMax] status.accessOk)
      else $error("power-up restore too long");
   cover property (status.asleep);
   cover property (!storeBusyPinOe_n && storeBusyPinOut);
   cover property (status.standby);
endmodule : nvs_sequencer_props
bind nvs_sequencer nvs_sequencer_props #(.RESTORE_CYC(RESTORE_CYC), .POWERUP_CYC(POWERUP_CYC))
   props_u (.clk_sys(clk_sys), .reset(reset), .supplyLow(supplyLow), .busStop(busStop),
   .busStart(busStart), .sramWriteDone(sramWriteDone), .storeBusyPinIn(storeBusyPinIn),
   .cmdIn(cmdIn), .storeBusyPinOut(storeBusyPinOut), .storeBusyPinOe_n(storeBusyPinOe_n),
   .status(status));
`default_nettype wire

// ---- testbench/tb_nvs_sequencer.sv ----
// Self-checking bench for nvs_sequencer.
// Assumes nvs_pin_model and the bound checker are compiled with it.
`default_nettype none
module tb_nvs_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, reset = 1'b1, supplyLow = 1'b0, pullLow = 1'b0;
   logic busStop = 1'b0, busStart = 1'b0, sramWriteDone = 1'b0;
   logic pinIn, pinOut, pinOe_n;
   nvs_pkg::nvs_cmd_s    cmdIn = '0;
   nvs_pkg::nvs_status_s st;
   int bad_count = 0, total_checks = 0, n, hi;
   always #10 clk_sys = ~clk_sys;
   nvs_sequencer #(.RESTORE_CYC(10), .SAVE_CYC(40), .POWERUP_CYC(20), .WAKE_CYC(20),
      .STANDBY_CYC(5)) dut_u (.clk_sys(clk_sys),
      .reset(reset), .supplyLow(supplyLow), .cmdIn(cmdIn), .busStop(busStop),
      .busStart(busStart), .sramWriteDone(sramWriteDone), .storeBusyPinIn(pinIn),
      .storeBusyPinOut(pinOut), .storeBusyPinOe_n(pinOe_n), .status(st));
   nvs_pin_model model_u (.clk_sys(clk_sys), .pullLow(pullLow), .storeBusyPinOut(pinOut),
      .storeBusyPinOe_n(pinOe_n), .pinLevel(pinIn));
   task automatic chk(input logic [15:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   task automatic chk_le(input logic [15:0] lim, got);
      chk(lim, (got <= lim) ? lim : got);
   endtask : chk_le
   function automatic bit hit(input int w);
      case (w)
         0: return st.accessOk === 1'b1;
         1: return pinOe_n === 1'b0 && pinOut === 1'b0;
         2: return st.asleep === 1'b1;
         default: return st.standby === 1'b1;
      endcase
   endfunction : hit
   task automatic wait_for(input int w);
      n = 0;
      hi = 0;
      do begin
         @(negedge clk_sys);
         n++;
         hi += (pinOe_n === 1'b0 && pinOut === 1'b1);
      end while (!hit(w) && n < 400);
   endtask : wait_for
   task automatic pulse(input int w);
      @(posedge clk_sys);
      case (w)
         0: sramWriteDone <= 1'b1;
         1: busStart <= 1'b1;
         2: busStop <= 1'b1;
         default: pullLow <= 1'b1;
      endcase
      @(posedge clk_sys);
      {sramWriteDone, busStart, busStop, pullLow} <= 4'h0;
   endtask : pulse
   task automatic send(input nvs_pkg::nvs_op_e op);
      @(posedge clk_sys);
      cmdIn <= '{1'b1, op};
      @(posedge clk_sys);
      cmdIn.valid <= 1'b0;
   endtask : send
   task automatic t_restore();
      // The no-operation code must leave the block idle
      send(nvs_pkg::NVS_OP_NONE);
      @(negedge clk_sys);
      chk(16'h0001, {15'h0, st.accessOk});
      send(nvs_pkg::NVS_OP_RESTORE);
      wait_for(1);
      chk_le(16'h0007, n[15:0]);
      chk(16'h0000, {15'h0, st.accessOk});
      send(nvs_pkg::NVS_OP_SAVE);
      wait_for(0);
      chk_le(16'h000D, n[15:0]);
      repeat (8) @(negedge clk_sys);
      chk(16'h0001, {15'h0, pinOe_n});
      $display("restore done");
   endtask : t_restore
   task automatic t_save();
      pulse(0);
      send(nvs_pkg::NVS_OP_SAVE);
      wait_for(1);
      chk_le(16'h0007, n[15:0]);
      @(negedge clk_sys);
      chk(16'h0001, {15'h0, st.busy});
      wait_for(0);
      chk_le(16'h0050, n[15:0]);
      chk_le(16'h0019, hi[15:0]);
      chk(16'h0001, {15'h0, hi != 0});
      chk(16'h0000, {15'h0, st.busy});
      $display("save done");
   endtask : t_save
   task automatic t_pin();
      @(posedge clk_sys);
      pullLow <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(16'h0000, {15'h0, st.accessOk});
      chk(16'h0001, {15'h0, pinOe_n});
      pulse(2);
      wait_for(0);
      chk_le(16'h00FB, n[15:0]);
      pulse(0);
      pulse(3);
      wait_for(1);
      chk_le(16'h0005, n[15:0]);
      wait_for(0);
      chk_le(16'h0050, n[15:0]);
      $display("pin save done");
   endtask : t_pin
   task automatic t_sleep();
      send(nvs_pkg::NVS_OP_SLEEP);
      wait_for(2);
      chk_le(16'h000A, n[15:0]);
      pulse(1);
      wait_for(0);
      chk_le(16'h0019, n[15:0]);
      pulse(2);
      wait_for(3);
      chk_le(16'h0008, n[15:0]);
      $display("sleep done");
   endtask : t_sleep
   task automatic t_powerdown();
      // Clean array: low supply blocks access but starts no save
      @(posedge clk_sys);
      supplyLow <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(16'h0001, {15'h0, pinOe_n});
      chk(16'h0000, {14'h0, st.accessOk, st.sramWriteEn});
      @(posedge clk_sys);
      supplyLow <= 1'b0;
      pulse(0);
      @(posedge clk_sys);
      supplyLow <= 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(16'h0001, {14'h0, st.accessOk, st.sramWriteEn});
      wait_for(1);
      chk_le(16'h0005, n[15:0]);
      chk(16'h0000, {15'h0, st.accessOk});
      $display("power-down done");
   endtask : t_powerdown
   // Supply returns: a fresh trip release must restore again in time
   task automatic t_reset();
      @(posedge clk_sys);
      reset     <= 1'b1;
      supplyLow <= 1'b0;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      wait_for(0);
      chk_le(16'h0017, n[15:0]);
      $display("reset done");
   endtask : t_reset
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report
   initial begin
      #100us;
      bad_count++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      wait_for(0);
      chk_le(16'h0017, n[15:0]);
      @(negedge clk_sys);
      chk(16'h0001, {15'h0, pinOe_n});
      t_restore();
      t_save();
      t_pin();
      t_sleep();
      t_powerdown();
      t_reset();
      final_report();
   end
endmodule : tb_nvs_sequencer
`default_nettype wire
